// ---- logic/dsr_pkg.sv ----
// Notes on behaviour
// RQ1: Load strobe low with direction high requests a read, low requests a write.
// RQ2: Read data launches on rises of both output strobes in normal mode.
// RQ3: Commands, addresses and first write word are captured on input strobe rise.
// RQ4: Every access begins only on a rise of the positive input strobe.
// RQ5: Second write word is captured on the rise of the negative input strobe.
// RQ6: In single clock mode read data launches on the input strobe rises.
// RQ7: Echo strobes follow the output strobes, or input strobes in single mode.
// RQ8: Each load strobe defines address and direction for a burst of two words.
// RQ9: Data outputs go high impedance whenever no read is being driven.
// RQ10: Byte selects sample with their word; deselected bytes stay unaltered.
package dsr_pkg;

  localparam int DATA_W = 18;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int BYTE_W = 9;
  localparam int BYTES = 2;
  localparam int SYNC_W = 31;

  localparam logic [DATA_W-1:0] DQ_RESET = 18'h00000;
  localparam logic DQ_OE_N_RESET = 1'b1;

  typedef enum logic [1:0] {
    DSR_RD_IDLE = 2'b00,
    DSR_RD_W0 = 2'b01,
    DSR_RD_W1 = 2'b10
  } dsr_rd_e;

  typedef enum logic [0:0] {
    DSR_WR_IDLE = 1'b0,
    DSR_WR_W1 = 1'b1
  } dsr_wr_e;

  // Pin inputs as they arrive, and again after synchronisation.
  typedef struct packed {
    logic load_strobe_n;
    logic rw_read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BYTES-1:0] byte_write_select_n;
    logic in_strobe_pos;
    logic in_strobe_neg;
    logic out_strobe_pos;
    logic out_strobe_neg;
    logic single_clk_mode;
  } dsr_pins_s;

endpackage : dsr_pkg

// ---- logic/dsr_sync.sv ----
`timescale 1ns/10ps
module dsr_sync
  import dsr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [SYNC_W-1:0] d,
  output logic [SYNC_W-1:0] q
);

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] meta_nxt;
  logic [SYNC_W-1:0] q_r;
  logic [SYNC_W-1:0] q_nxt;

  // ****************************************
  // Two flip-flop synchroniser per bit.
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_bit
      always_comb
      begin
        meta_nxt[gi] = ce ? d[gi] : meta_r[gi];
        q_nxt[gi] = ce ? meta_r[gi] : q_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : dsr_sync

// ---- logic/dsr_ddr2_core.sv ----
`timescale 1ns/10ps
module dsr_ddr2_core
  import dsr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic load_strobe_n,
  input wire logic rw_read,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [BYTES-1:0] byte_write_select_n,
  input wire logic in_strobe_pos,
  input wire logic in_strobe_neg,
  input wire logic out_strobe_pos,
  input wire logic out_strobe_neg,
  input wire logic single_clk_mode,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic echo_strobe_pos,
  output logic echo_strobe_neg
);

  // ****************************************
  // Input synchronisation and edge detection.
  // ****************************************
  dsr_pins_s raw;
  dsr_pins_s s;
  logic [SYNC_W-1:0] s_bits;

  assign raw = {load_strobe_n, rw_read, addr, dq_in, byte_write_select_n,
                in_strobe_pos, in_strobe_neg, out_strobe_pos, out_strobe_neg,
                single_clk_mode};

  dsr_sync u_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .d(raw),
    .q(s_bits)
  );

  assign s = dsr_pins_s'(s_bits);

  logic [3:0] lvl_r, lvl_nxt, lvl;
  logic k_rise, kn_rise, pos_launch, neg_launch, pos_level, neg_level;

  always_comb
  begin
    lvl = {s.in_strobe_pos, s.in_strobe_neg,
           s.out_strobe_pos, s.out_strobe_neg};
    lvl_nxt = ce ? lvl : lvl_r;
    k_rise = ce & lvl[3] & ~lvl_r[3];
    kn_rise = ce & lvl[2] & ~lvl_r[2];
    // Single clock mode times read data and echoes from the input strobes.
    pos_launch = s.single_clk_mode ? k_rise : (ce & lvl[1] & ~lvl_r[1]); // RQ2 RQ6
    neg_launch = s.single_clk_mode ? kn_rise : (ce & lvl[0] & ~lvl_r[0]); // RQ2 RQ6
    pos_level = s.single_clk_mode ? lvl[3] : lvl[1]; // RQ7
    neg_level = s.single_clk_mode ? lvl[2] : lvl[0]; // RQ7
  end

  // ****************************************
  // Command decode and storage array.
  // ****************************************
  logic cmd_rd, cmd_wr, we;
  logic [DATA_W-1:0] mem_r [DEPTH], mem_nxt [DEPTH];
  dsr_wr_e wr_st_r, wr_st_nxt;
  logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt, wa;

  assign cmd_rd = k_rise & ~s.load_strobe_n & s.rw_read; // RQ1 RQ3 RQ4
  assign cmd_wr = k_rise & ~s.load_strobe_n & ~s.rw_read; // RQ1 RQ3 RQ4

  always_comb
  begin
    mem_nxt = mem_r;
    wr_st_nxt = wr_st_r;
    wr_addr_nxt = wr_addr_r;
    we = 1'b0;
    wa = s.addr;
    if (cmd_wr)
    begin
      // First word lands with the command; the burst partner follows.
      we = 1'b1; // RQ3
      wr_addr_nxt = s.addr;
      wr_st_nxt = DSR_WR_W1; // RQ8
    end
    else if (wr_st_r == DSR_WR_W1 && kn_rise)
    begin
      we = 1'b1; // RQ5
      wa = wr_addr_r ^ {{(ADDR_W-1){1'b0}}, 1'b1}; // RQ8
      wr_st_nxt = DSR_WR_IDLE;
    end
    if (we)
    begin
      for (int b = 0; b < BYTES; b++)
      begin
        if (!s.byte_write_select_n[b]) // RQ10
        begin
          mem_nxt[wa][b*BYTE_W +: BYTE_W] = s.wdata[b*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_st_r <= DSR_WR_IDLE;
      wr_addr_r <= '0;
      mem_r <= '{default: '0};
    end
    else
    begin
      wr_st_r <= wr_st_nxt;
      wr_addr_r <= wr_addr_nxt;
      mem_r <= mem_nxt;
    end
  end

  // ****************************************
  // Read burst output and echo strobes.
  // ****************************************
  dsr_rd_e rd_st_r, rd_st_nxt;
  logic rd_pend_r, rd_pend_nxt, oe_n_r, oe_n_nxt, echo_p_r, echo_n_r;
  logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt, act_addr_r, act_addr_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt, peek0, peek1;

  always_comb
  begin
    peek0 = mem_r[rd_addr_r];
    peek1 = mem_r[act_addr_r ^ {{(ADDR_W-1){1'b0}}, 1'b1}];
    rd_st_nxt = rd_st_r;
    rd_addr_nxt = cmd_rd ? s.addr : rd_addr_r;
    act_addr_nxt = act_addr_r;
    dq_nxt = dq_r;
    oe_n_nxt = oe_n_r;
    // A pending read launches on the next launch rise, not the command's own.
    rd_pend_nxt = cmd_rd | (rd_pend_r & ~pos_launch); // RQ4
    case (rd_st_r)
      DSR_RD_IDLE, DSR_RD_W1:
      begin
        if (pos_launch && rd_pend_r)
        begin
          dq_nxt = peek0; // RQ2 RQ6
          oe_n_nxt = 1'b0;
          act_addr_nxt = rd_addr_r;
          rd_st_nxt = DSR_RD_W0;
        end
        else if (pos_launch && rd_st_r == DSR_RD_W1)
        begin
          oe_n_nxt = 1'b1; // RQ9
          rd_st_nxt = DSR_RD_IDLE;
        end
      end
      DSR_RD_W0:
      begin
        if (neg_launch)
        begin
          dq_nxt = peek1; // RQ2 RQ8
          rd_st_nxt = DSR_RD_W1;
        end
      end
      default:
      begin
        oe_n_nxt = 1'b1;
        rd_st_nxt = DSR_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_st_r <= DSR_RD_IDLE;
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
      act_addr_r <= '0;
      dq_r <= DQ_RESET;
      oe_n_r <= DQ_OE_N_RESET;
      echo_p_r <= 1'b0;
      echo_n_r <= 1'b0;
      lvl_r <= '0;
    end
    else
    begin
      rd_st_r <= rd_st_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_addr_r <= rd_addr_nxt;
      act_addr_r <= act_addr_nxt;
      dq_r <= dq_nxt;
      oe_n_r <= oe_n_nxt;
      echo_p_r <= ce ? pos_level : echo_p_r; // RQ7
      echo_n_r <= ce ? neg_level : echo_n_r; // RQ7
      lvl_r <= lvl_nxt;
    end
  end

  assign dq_out = dq_r;
  assign dq_oe_n = oe_n_r;
  assign echo_strobe_pos = echo_p_r;
  assign echo_strobe_neg = echo_n_r;

  // ****************************************
  // Assertions.
  // ****************************************
  logic [BYTE_W-1:0] wr_lo_peek, wr_hi_peek, cmd_hi_peek, w1_lo_peek;

  always_comb
  begin
    wr_lo_peek = mem_r[wr_addr_r][BYTE_W-1:0];
    wr_hi_peek = mem_r[wr_addr_r][DATA_W-1:BYTE_W];
    cmd_hi_peek = mem_r[s.addr][DATA_W-1:BYTE_W];
    w1_lo_peek = mem_r[wr_addr_r ^ {{(ADDR_W-1){1'b0}}, 1'b1}][BYTE_W-1:0];
  end

  property p_rd_launch; // RQ2
    @(posedge clk) disable iff (srst)
    (rd_pend_r && pos_launch && rd_st_r != DSR_RD_W0)
      |=> (!dq_oe_n && dq_out == $past(peek0));
  endproperty
  a_rd_launch: assert property (p_rd_launch) // RQ2
    else $error("Read word 0 not launched on the launch rise.");
  property p_single_mode; // RQ6
    @(posedge clk) disable iff (srst)
    (s.single_clk_mode && rd_pend_r && k_rise && rd_st_r != DSR_RD_W0)
      |=> (rd_st_r == DSR_RD_W0 && !dq_oe_n);
  endproperty
  a_single_mode: assert property (p_single_mode) // RQ6
    else $error("Single clock mode read did not follow input strobe.");
  property p_burst_second; // RQ8
    @(posedge clk) disable iff (srst)
    (rd_st_r == DSR_RD_W0 && neg_launch)
      |=> (rd_st_r == DSR_RD_W1 && dq_out == $past(peek1) && !dq_oe_n);
  endproperty
  a_burst_second: assert property (p_burst_second) // RQ8
    else $error("Second burst word not driven on negative launch rise.");
  property p_release; // RQ9
    @(posedge clk) disable iff (srst)
    (rd_st_r == DSR_RD_W1 && pos_launch && !rd_pend_r) |=> dq_oe_n;
  endproperty
  a_release: assert property (p_release) // RQ9
    else $error("Data outputs not released after the burst.");
  property p_idle_hiz; // RQ9
    @(posedge clk) disable iff (srst)
    (rd_st_r == DSR_RD_IDLE) |-> dq_oe_n;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) // RQ9
    else $error("Data outputs driven while no read is active.");
  property p_wr_first; // RQ3
    @(posedge clk) disable iff (srst)
    (cmd_wr && !s.byte_write_select_n[0])
      |=> (wr_lo_peek == $past(s.wdata[BYTE_W-1:0]));
  endproperty
  a_wr_first: assert property (p_wr_first) // RQ3
    else $error("First write word not stored with the command.");
  property p_bws_keep; // RQ10
    @(posedge clk) disable iff (srst)
    (cmd_wr && s.byte_write_select_n[1]) |=> (wr_hi_peek == $past(cmd_hi_peek));
  endproperty
  a_bws_keep: assert property (p_bws_keep) // RQ10
    else $error("Deselected byte was altered by a write.");
  property p_wr_second; // RQ5
    @(posedge clk) disable iff (srst)
    (wr_st_r == DSR_WR_W1 && kn_rise && !cmd_wr && !s.byte_write_select_n[0])
      |=> (w1_lo_peek == $past(s.wdata[BYTE_W-1:0]) && wr_st_r == DSR_WR_IDLE);
  endproperty
  a_wr_second: assert property (p_wr_second) // RQ5
    else $error("Second write word not captured on negative strobe.");
  property p_start_k; // RQ4
    @(posedge clk) disable iff (srst)
    (!k_rise && !pos_launch) |=> $stable(rd_pend_r);
  endproperty
  a_start_k: assert property (p_start_k) // RQ4
    else $error("Read request changed without an input strobe rise.");
  property p_echo; // RQ7
    @(posedge clk) disable iff (srst)
    ce |=> (echo_strobe_pos == $past(pos_level) &&
            echo_strobe_neg == $past(neg_level));
  endproperty
  a_echo: assert property (p_echo) // RQ7
    else $error("Echo strobes do not follow the timing strobes.");
  property p_dir; // RQ1
    @(posedge clk) disable iff (srst)
    cmd_rd |=> (rd_pend_r && rd_addr_r == $past(s.addr));
  endproperty
  a_dir: assert property (p_dir) // RQ1
    else $error("Read command not recorded at the loaded address.");

endmodule : dsr_ddr2_core

// ---- tb/dsr_bfm.sv ----
`timescale 1ns/10ps
// ****
// Controller side: strobes stand still outside transfers.
// ****
module dsr_bfm
  import dsr_pkg::*;
#(
  parameter int HOLD = 6
)
(
  input wire logic clk,
  output logic load_strobe_n,
  output logic rw_read,
  output logic [ADDR_W-1:0] addr,
  output logic [BYTES-1:0] byte_write_select_n,
  output logic [DATA_W-1:0] dq_in,
  output logic in_strobe_pos,
  output logic in_strobe_neg,
  output logic out_strobe_pos,
  output logic out_strobe_neg
);
  logic [3:0] stb = 4'h0;
  assign {out_strobe_neg, out_strobe_pos, in_strobe_neg, in_strobe_pos} = stb;
  initial
  begin
    load_strobe_n = 1'b1;
    rw_read = 1'b0;
    addr = '0;
    byte_write_select_n = '1;
    dq_in = '0;
  end
  task automatic rise(input int i);
    @(posedge clk);
    stb[i] <= 1'b1;
    repeat (HOLD) @(negedge clk);
  endtask : rise
  task automatic fall(input int i);
    @(posedge clk);
    stb[i] <= 1'b0;
    repeat (HOLD) @(negedge clk);
  endtask : fall
  task automatic cmd(input logic ld_n, rd, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [BYTES-1:0] be);
    @(posedge clk);
    load_strobe_n <= ld_n;
    rw_read <= rd;
    addr <= a;
    dq_in <= d;
    byte_write_select_n <= be;
    stb[0] <= 1'b1;
    repeat (HOLD) @(negedge clk);
    @(posedge clk);
    load_strobe_n <= 1'b1;
    rw_read <= ~rd;
    addr <= ~a;
    dq_in <= ~d;
    byte_write_select_n <= ~be;
    stb[0] <= 1'b0;
    repeat (HOLD) @(negedge clk);
  endtask : cmd
  task automatic wdata(input logic [DATA_W-1:0] d, input logic [BYTES-1:0] be);
    @(posedge clk);
    dq_in <= d;
    byte_write_select_n <= be;
    stb[1] <= 1'b1;
    repeat (HOLD) @(negedge clk);
    @(posedge clk);
    dq_in <= ~d;
    byte_write_select_n <= ~be;
    stb[1] <= 1'b0;
    repeat (HOLD) @(negedge clk);
  endtask : wdata
endmodule : dsr_bfm

// ---- tb/tb_dsr_ddr2_core.sv ----
`timescale 1ns/10ps
module tb_dsr_ddr2_core;
  import dsr_pkg::*;
  logic clk, srst, ce, scm, ld_n, rw, oe_n, eq_p, eq_n;
  logic isp, isn, osp, osn;
  logic [ADDR_W-1:0] a;
  logic [BYTES-1:0] bws_n;
  logic [DATA_W-1:0] di, dq;
  logic [DATA_W-1:0] exp_mem [DEPTH];
  int num_errors = 0;
  int num_checks = 0;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  dsr_bfm u_dsr_bfm (.clk(clk), .load_strobe_n(ld_n), .rw_read(rw),
    .addr(a), .byte_write_select_n(bws_n), .dq_in(di),
    .in_strobe_pos(isp), .in_strobe_neg(isn), .out_strobe_pos(osp),
    .out_strobe_neg(osn));
  dsr_ddr2_core u_dsr_ddr2_core (.clk(clk), .srst(srst), .ce(ce),
    .load_strobe_n(ld_n), .rw_read(rw), .addr(a),
    .byte_write_select_n(bws_n), .in_strobe_pos(isp), .in_strobe_neg(isn),
    .out_strobe_pos(osp), .out_strobe_neg(osn), .single_clk_mode(scm),
    .dq_in(di), .dq_out(dq), .dq_oe_n(oe_n), .echo_strobe_pos(eq_p),
    .echo_strobe_neg(eq_n));
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
                                              input logic [BYTES-1:0] be);
    for (int b = 0; b < BYTES; b++)
      if (!be[b])
        o[b*BYTE_W +: BYTE_W] = n[b*BYTE_W +: BYTE_W];
    return o;
  endfunction : merge
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] w0,
                    input logic [BYTES-1:0] b0, input logic [DATA_W-1:0] w1,
                    input logic [BYTES-1:0] b1);
    u_dsr_bfm.cmd(1'b0, 1'b0, ad, w0, b0);
    u_dsr_bfm.wdata(w1, b1);
    exp_mem[ad] = merge(exp_mem[ad], w0, b0);
    exp_mem[ad^4'h1] = merge(exp_mem[ad^4'h1], w1, b1);
  endtask : wr
  // Reads one burst and follows it through launch and release.
  task automatic rd(input logic [ADDR_W-1:0] ad, input int s);
    int p;
    p = s ? 0 : 2;
    u_dsr_bfm.cmd(1'b0, 1'b1, ad, 18'h0, 2'h3);
    chk(oe_n === 1'b1, "driven early");
    u_dsr_bfm.rise(p);
    chk(eq_p === 1'b1, "echo pos high");
    chk(dq === exp_mem[ad] && oe_n === 1'b0, "word0");
    u_dsr_bfm.fall(p);
    chk(eq_p === 1'b0, "echo pos low");
    u_dsr_bfm.rise(p + 1);
    chk(eq_n === 1'b1, "echo neg high");
    chk(dq === exp_mem[ad^4'h1] && oe_n === 1'b0, "word1");
    u_dsr_bfm.fall(p + 1);
    chk(eq_n === 1'b0, "echo neg low");
    u_dsr_bfm.rise(p);
    chk(oe_n === 1'b1, "not released");
    u_dsr_bfm.fall(p);
  endtask : rd
  task automatic test_reset;
    chk(dq === DQ_RESET && oe_n === DQ_OE_N_RESET, "reset outputs");
    rd(4'h3, 0);
  endtask : test_reset
  task automatic test_write_read;
    wr(4'h8, 18'h2a5c3, 2'h0, 18'h15a3c, 2'h0);
    wr(4'h2, 18'h0f0f0, 2'h0, 18'h30303, 2'h0);
    rd(4'h8, 0);
    rd(4'h9, 0);
    rd(4'h3, 0);
  endtask : test_write_read
  task automatic test_byte_sel;
    wr(4'h9, 18'h3ffff, 2'h2, 18'h00000, 2'h1);
    rd(4'h9, 0);
  endtask : test_byte_sel
  task automatic test_no_load;
    u_dsr_bfm.cmd(1'b1, 1'b0, 4'h8, 18'h11111, 2'h0);
    u_dsr_bfm.wdata(18'h22222, 2'h0);
    rd(4'h8, 0);
  endtask : test_no_load
  task automatic test_pending;
    u_dsr_bfm.cmd(1'b0, 1'b1, 4'h3, 18'h0, 2'h3);
    rd(4'h9, 0);
  endtask : test_pending
  task automatic test_single;
    @(posedge clk);
    scm <= 1'b1;
    repeat (4) @(negedge clk);
    wr(4'h6, 18'h12345, 2'h0, 18'h2bcde, 2'h0);
    rd(4'h6, 1);
    u_dsr_bfm.rise(2);
    chk(eq_p === 1'b0 && oe_n === 1'b1, "output strobe used");
    u_dsr_bfm.fall(2);
    @(posedge clk);
    scm <= 1'b0;
    repeat (4) @(negedge clk);
    rd(4'h6, 0);
  endtask : test_single
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    scm = 1'b0;
    foreach (exp_mem[i])
      exp_mem[i] = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    test_reset;
    test_write_read;
    test_byte_sel;
    test_no_load;
    test_pending;
    test_single;
    final_report;
  end
  initial
  begin
    repeat (8000) @(posedge clk);
    num_errors++;
    final_report;
  end
endmodule : tb_dsr_ddr2_core
